// *** design/wfd_pkg.sv ***
// Package for the complementary waveform dead-band stage.
// Assumes a single 20 MHz core clock and an AXI4-Lite register bus.
package wfd_pkg;
  localparam int unsigned         COUNT_W        = 6;
  localparam logic [11:0]         OFS_RISE       = 12'h000;
  localparam logic [11:0]         OFS_FALL       = 12'h004;
  localparam logic [11:0]         OFS_CTRL       = 12'h008;
  localparam logic [11:0]         OFS_STAT       = 12'h00C;
  localparam logic [COUNT_W-1:0]  RISE_RESET     = 6'h00;
  localparam logic [COUNT_W-1:0]  FALL_RESET     = 6'h00;
  localparam logic [1:0]          LEVEL_RESET_BD = 2'h1;
  localparam logic [1:0]          LEVEL_RESET_AC = 2'h1;
  localparam int unsigned         FIELD_LSB      = 0;
  localparam int unsigned         CTRL_PAIR_AC_SHUTDOWN_LEVEL_LSB  = 0;
  localparam int unsigned         CTRL_PAIR_BD_SHUTDOWN_LEVEL_LSB  = 2;
  localparam int unsigned         CTRL_POL_LSB   = 4;
  localparam logic [1:0]          SHUT_INACTIVE  = 2'h0;
  localparam logic [1:0]          SHUT_TRISTATE  = 2'h1;
  localparam logic [1:0]          SHUT_LOW       = 2'h2;
  localparam logic [1:0]          SHUT_HIGH      = 2'h3;
  localparam logic [1:0]          RESP_OKAY      = 2'h0;
  localparam logic [1:0]          RESP_SLVERR    = 2'h2;

  typedef struct packed {
    logic        awvalid;
    logic [11:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [11:0] araddr;
    logic        rready;
  } wfd_axi_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } wfd_axi_rsp_s;

  // Outputs A..D: value and drive enable
  typedef struct packed {
    logic [3:0] level;
    logic [3:0] oe;
  } wfd_drive_s;
endpackage

// *** design/wfd_deadband.sv ***
// Complementary waveform dead-band stage with rising and falling delays.
// Assumes pwm input on core_clk, gen_tick as the generator clock enable.
// Behaviour
// RULE1: Six-bit writable falling count register field
// RULE2: Nonzero count n delays n to n+1 ticks
// RULE3: Zero count bypasses falling delay
// RULE4: Upper two bits read zero, ignore writes
// RULE5: Falling count clears on every reset
// RULE6: Rising count same encoding, zero bypasses
// RULE7: Inactive shutdown level waits out dead-band
// RULE8: Falling edge restarts counter, holds output off
`timescale 1ns/10ps
`default_nettype none
module wfd_deadband
  import wfd_pkg::*;
(
  // Clock and reset
  input  wire logic               core_clk,
  input  wire logic               rst_b,
  // Register bus
  input  wire wfd_pkg::wfd_axi_req_s axi_req,
  output wfd_pkg::wfd_axi_rsp_s   axi_rsp,
  // Generator
  input  wire logic               gen_tick,
  input  wire logic               data_in,
  input  wire logic               shutdown_in,
  // Output drive
  output wfd_pkg::wfd_drive_s     drive
);
  import wfd_pkg::*;

  typedef struct packed {
    logic [COUNT_W-1:0] rise_cnt;
    logic [COUNT_W-1:0] fall_cnt;
    logic [1:0]         lvl_ac;
    logic [1:0]         lvl_bd;
    logic [3:0]         pol;
    logic [COUNT_W:0]   rise_tmr;
    logic [COUNT_W:0]   fall_tmr;
    logic               data_d;
    logic               out_a;
    logic               out_b;
    logic               shut_d;
    logic               aw_got;
    logic [11:0]        aw_addr;
    logic               w_got;
    logic [31:0]        w_data;
    logic [3:0]         w_strb;
    logic               bvalid;
    logic [1:0]         bresp;
    logic               rvalid;
    logic [31:0]        rdata;
    logic [1:0]         rresp;
    wfd_drive_s         drive;
  } wfd_state_s;

  wfd_state_s st_reg;
  wfd_state_s st_next;

  localparam wfd_state_s ST_RESET = '{
    rise_cnt: RISE_RESET, fall_cnt: FALL_RESET,
    lvl_ac: LEVEL_RESET_AC, lvl_bd: LEVEL_RESET_BD,
    pol: 4'h0, rise_tmr: '0, fall_tmr: '0, data_d: 1'b0,
    out_a: 1'b0, out_b: 1'b0, shut_d: 1'b0,
    aw_got: 1'b0, aw_addr: 12'h000, w_got: 1'b0, w_data: 32'h0000_0000,
    w_strb: 4'h0, bvalid: 1'b0, bresp: RESP_OKAY, rvalid: 1'b0,
    rdata: 32'h0000_0000, rresp: RESP_OKAY,
    drive: '{level: 4'h0, oe: 4'h0}};

  function automatic logic [1:0] shut_pair(input logic [1:0] sel, input logic inact,
                                           input logic ready, input logic cur);
    shut_pair = {1'b1, cur};
    unique case (sel)
      SHUT_INACTIVE: shut_pair = ready ? {1'b1, inact} : {1'b1, cur}; // [RULE7]
      SHUT_TRISTATE: shut_pair = 2'b00;
      SHUT_LOW:      shut_pair = 2'b10;
      SHUT_HIGH:     shut_pair = 2'b11;
    endcase
  endfunction

  logic               rd_ok;
  logic [31:0]        rd_val;
  logic               wr_fire;
  logic               rise_edge;
  logic               fall_edge;
  logic               a_raw;
  logic               b_raw;
  logic [1:0]         ac_drv;
  logic [1:0]         bd_drv;
  logic               db_idle;
  logic               aw_rdy;
  logic               w_rdy;
  logic [3:0]         inact_mask;

  always_comb begin
    st_next = st_reg;
    rd_ok   = 1'b1;
    rd_val  = 32'h0000_0000;
    db_idle = st_reg.rise_tmr == '0 && st_reg.fall_tmr == '0;
    // No new write is taken while a response waits for bready
    aw_rdy  = !st_reg.aw_got && !st_reg.bvalid;
    w_rdy   = !st_reg.w_got && !st_reg.bvalid;
    // In shutdown, polarity applies only to a pair set to its inactive level
    inact_mask = {st_reg.lvl_bd == SHUT_INACTIVE, st_reg.lvl_ac == SHUT_INACTIVE,
                  st_reg.lvl_bd == SHUT_INACTIVE, st_reg.lvl_ac == SHUT_INACTIVE};
    unique case (axi_req.araddr)
      OFS_RISE: rd_val[FIELD_LSB +: COUNT_W] = st_reg.rise_cnt; // [RULE4]
      OFS_FALL: rd_val[FIELD_LSB +: COUNT_W] = st_reg.fall_cnt; // [RULE4]
      OFS_CTRL: rd_val[7:0] = {st_reg.pol, st_reg.lvl_bd, st_reg.lvl_ac};
      OFS_STAT: rd_val[3:0] = {st_reg.shut_d, db_idle, st_reg.out_b, st_reg.out_a};
      default:  rd_ok = 1'b0;
    endcase

    // Write address and data may arrive in either order
    if (axi_req.awvalid && aw_rdy) begin
      st_next.aw_got  = 1'b1;
      st_next.aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid && w_rdy) begin
      st_next.w_got  = 1'b1;
      st_next.w_data = axi_req.wdata;
      st_next.w_strb = axi_req.wstrb;
    end
    wr_fire = st_reg.aw_got && st_reg.w_got && !st_reg.bvalid;
    if (wr_fire) begin
      st_next.aw_got = 1'b0;
      st_next.w_got  = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp  = RESP_OKAY;
      if (st_reg.w_strb[0]) begin
        unique case (st_reg.aw_addr)
          OFS_RISE: st_next.rise_cnt = st_reg.w_data[FIELD_LSB +: COUNT_W]; // [RULE6]
          OFS_FALL: st_next.fall_cnt = st_reg.w_data[FIELD_LSB +: COUNT_W]; // [RULE1] [RULE4]
          OFS_CTRL: begin
            st_next.lvl_ac = st_reg.w_data[CTRL_PAIR_AC_SHUTDOWN_LEVEL_LSB +: 2];
            st_next.lvl_bd = st_reg.w_data[CTRL_PAIR_BD_SHUTDOWN_LEVEL_LSB +: 2];
            st_next.pol    = st_reg.w_data[CTRL_POL_LSB +: 4];
          end
          OFS_STAT: st_next.bresp = RESP_OKAY;
          default:  st_next.bresp = RESP_SLVERR;
        endcase
      end else if (st_reg.aw_addr != OFS_RISE && st_reg.aw_addr != OFS_FALL &&
                   st_reg.aw_addr != OFS_CTRL && st_reg.aw_addr != OFS_STAT) begin
        st_next.bresp = RESP_SLVERR;
      end
    end
    if (st_reg.bvalid && axi_req.bready) begin
      st_next.bvalid = 1'b0;
    end
    if (axi_req.arvalid && !st_reg.rvalid) begin
      st_next.rvalid = 1'b1;
      st_next.rdata  = rd_val;
      st_next.rresp  = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (st_reg.rvalid && axi_req.rready) begin
      st_next.rvalid = 1'b0;
    end

    // Dead-band timers count generator ticks
    st_next.data_d = data_in;
    rise_edge = data_in && !st_reg.data_d;
    fall_edge = !data_in && st_reg.data_d;
    if (rise_edge) begin
      st_next.rise_tmr = {1'b0, st_reg.rise_cnt} + 7'd1; // [RULE6]
      st_next.fall_tmr = '0;
    end else if (gen_tick && st_reg.rise_tmr != '0) begin
      st_next.rise_tmr = st_reg.rise_tmr - 7'd1;
    end
    if (fall_edge) begin
      st_next.fall_tmr = {1'b0, st_reg.fall_cnt} + 7'd1; // [RULE8] [RULE2]
      st_next.rise_tmr = '0;
    end else if (gen_tick && st_reg.fall_tmr != '0) begin
      st_next.fall_tmr = st_reg.fall_tmr - 7'd1; // [RULE2]
    end
    // Zero count means no delay: output follows input directly
    a_raw = data_in && (st_reg.rise_cnt == '0 ||
            (!rise_edge && st_reg.rise_tmr == 7'd1 && gen_tick) ||
            (!rise_edge && st_reg.rise_tmr == '0 && st_reg.out_a)); // [RULE6]
    b_raw = !data_in && (st_reg.fall_cnt == '0 ||
            (!fall_edge && st_reg.fall_tmr == 7'd1 && gen_tick) ||
            (!fall_edge && st_reg.fall_tmr == '0 && st_reg.out_b)); // [RULE3] [RULE8]
    st_next.out_a = a_raw;
    st_next.out_b = b_raw;

    // Shutdown and polarity onto the four outputs
    st_next.shut_d = shutdown_in;
    ac_drv = shut_pair(st_reg.lvl_ac, 1'b0, db_idle, st_reg.out_a);
    bd_drv = shut_pair(st_reg.lvl_bd, 1'b0, db_idle, st_reg.out_b);
    if (st_reg.shut_d) begin
      st_next.drive.oe    = {bd_drv[1], ac_drv[1], bd_drv[1], ac_drv[1]};
      st_next.drive.level = {bd_drv[0], ac_drv[0], bd_drv[0], ac_drv[0]} ^
                            (inact_mask & st_reg.pol); // [RULE7]
    end else begin
      st_next.drive.oe    = 4'hF;
      st_next.drive.level = {st_reg.out_b, st_reg.out_a, st_reg.out_b, st_reg.out_a} ^
                            st_reg.pol;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= ST_RESET; // [RULE5]
    end else begin
      st_reg <= st_next;
    end
  end

  assign axi_rsp.awready = aw_rdy;
  assign axi_rsp.wready  = w_rdy;
  assign axi_rsp.bvalid  = st_reg.bvalid;
  assign axi_rsp.bresp   = st_reg.bresp;
  assign axi_rsp.arready = !st_reg.rvalid;
  assign axi_rsp.rvalid  = st_reg.rvalid;
  assign axi_rsp.rdata   = st_reg.rdata;
  assign axi_rsp.rresp   = st_reg.rresp;
  assign drive           = st_reg.drive;
endmodule
`default_nettype wire

// *** tb/wfd_chk_assertions.sv ***
// Checker: bus handshakes and output non-overlap of the dead-band stage.
// Assumes a bind into wfd_deadband and one clock domain.
`timescale 1ns/10ps
`default_nettype none
module wfd_chk
  import wfd_pkg::*;
(
  // Clock and reset
  input wire logic                  core_clk,
  input wire logic                  rst_b,
  // Bus and drive
  input wire wfd_pkg::wfd_axi_req_s axi_req,
  input wire wfd_pkg::wfd_axi_rsp_s axi_rsp,
  input wire wfd_pkg::wfd_drive_s   drive,
  // Generator
  input wire logic                  shutdown_in
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  wr_answer_a: assert property (axi_req.awvalid && axi_rsp.awready && axi_req.wvalid
    && axi_rsp.wready |-> ##[1:3] axi_rsp.bvalid) else $error("late write response");
  rd_answer_a: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
    else $error("late read data");
  b_once_a: assert property (axi_rsp.bvalid && axi_req.bready |=> !axi_rsp.bvalid)
    else $error("write response repeated");
  r_once_a: assert property (axi_rsp.rvalid && axi_req.rready |=> !axi_rsp.rvalid)
    else $error("read data repeated");
  upper_zero_a: assert property (axi_rsp.rvalid && axi_rsp.rresp == RESP_OKAY
    |-> axi_rsp.rdata[31:8] == 24'h00_0000) else $error("upper read bits set");
  ar_block_a: assert property (axi_rsp.rvalid |-> !axi_rsp.arready)
    else $error("read address taken early");
  aw_block_a: assert property (axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready)
    else $error("write taken early");
  no_overlap_a: assert property (!shutdown_in && !$past(shutdown_in)
    && !$past(shutdown_in, 2) && &drive.oe[1:0] |-> !(drive.level[0] && drive.level[1]))
    else $error("both outputs active");
  cover property (axi_rsp.rvalid && axi_rsp.rresp == RESP_SLVERR);
  cover property ($rose(drive.level[1]));
  cover property ($rose(drive.level[0]));
endmodule
bind wfd_deadband wfd_chk chk_u(.core_clk(core_clk), .rst_b(rst_b), .axi_req(axi_req),
  .axi_rsp(axi_rsp), .drive(drive), .shutdown_in(shutdown_in));
`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking bench: registers, dead-band timing, reset and shutdown.
// Assumes the checker is bound separately; generator tick every eighth clock.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import wfd_pkg::*;
  logic         core_clk = 0, rst_b = 0, gen_tick = 0, data_in = 1, shutdown_in = 0;
  wfd_axi_req_s req = '0;
  wfd_axi_rsp_s rsp;
  wfd_drive_s   drv;
  logic [33:0]  exp_q[$];
  logic [31:0]  seed = 71, r;
  logic [2:0]   tk = 0;
  int           n_mismatch = 0, checks_done = 0, n, lo, hi;
  int           nl[4] = '{0, 1, 5, 63};
  wfd_deadband dut_u(.core_clk(core_clk), .rst_b(rst_b), .axi_req(req), .axi_rsp(rsp),
    .gen_tick(gen_tick), .data_in(data_in), .shutdown_in(shutdown_in), .drive(drv));
  always #25 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    tk <= tk + 3'h1;
    gen_tick <= (tk == 3'h7);
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic miss(string m);
    n_mismatch++;
    $display("unexpected at %0t: %s", $time, m);
  endtask
  task automatic cmp_bus(logic [33:0] e, logic [33:0] g);
    checks_done++;
    if (g !== e) miss($sformatf("bus got %h want %h", g, e));
  endtask
  task automatic cmp_win(int c, int l, int h);
    checks_done++;
    if (c < l || c > h) miss($sformatf("delay %0d not in %0d..%0d", c, l, h));
  endtask
  task automatic cmp_drv(logic [7:0] e);
    checks_done++;
    if (drv !== e) miss($sformatf("drive got %h want %h", drv, e));
  endtask
  task automatic bound(int i);
    if (i >= 60) begin
      miss("bus wait ran out");
      tally_and_finish();
    end
  endtask
  // Master holds each valid until its own ready edge
  task automatic wr(logic [11:0] a, logic [31:0] d, logic [1:0] e);
    int i;
    @(posedge core_clk);
    exp_q.push_back({e, 32'h0});
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.awvalid <= 1;
    req.wvalid <= 1;
    req.bready <= 1;
    for (i = 0; i < 60; i++) begin
      @(posedge core_clk);
      if (req.awvalid && rsp.awready) req.awvalid <= 0;
      if (req.wvalid && rsp.wready) req.wvalid <= 0;
      if (rsp.bvalid === 1'b1) break;
    end
    req.bready <= 0;
    bound(i);
  endtask
  task automatic rd(logic [11:0] a, logic [31:0] d, logic [1:0] e);
    int i;
    @(posedge core_clk);
    exp_q.push_back({e, d});
    req.araddr <= a;
    req.arvalid <= 1;
    req.rready <= 1;
    for (i = 0; i < 60; i++) begin
      @(posedge core_clk);
      if (req.arvalid && rsp.arready) req.arvalid <= 0;
      if (rsp.rvalid === 1'b1) break;
    end
    req.rready <= 0;
    bound(i);
  endtask
  always @(posedge core_clk) begin
    if (rsp.bvalid === 1'b1 && req.bready) cmp_bus(exp_q.pop_front(), {rsp.bresp, 32'h0});
    if (rsp.rvalid === 1'b1 && req.rready) cmp_bus(exp_q.pop_front(),
      {rsp.rresp, (rsp.rresp === RESP_OKAY) ? rsp.rdata : 32'h0});
  end
  // Counts edges until output bit b reaches level v
  task automatic meas(int b, logic v, int l, int h);
    int c;
    for (c = 1; c < 700; c++) begin
      @(posedge core_clk);
      if (drv.level[b] === v) break;
    end
    cmp_win(c, l, h);
    if (c >= 700) tally_and_finish();
  endtask
  initial begin
    repeat (2) @(posedge core_clk);
    rst_b <= 1;
    rd(OFS_RISE, 0, RESP_OKAY);
    rd(OFS_FALL, 0, RESP_OKAY);
    wr(12'h010, xs(), RESP_SLVERR);
    rd(12'h010, 0, RESP_SLVERR);
    $display("test registers done");
    foreach (nl[k]) begin
      n = nl[k];
      r = xs();
      wr(OFS_RISE, {r[31:6], n[5:0]}, RESP_OKAY);
      wr(OFS_FALL, {r[25:0], n[5:0]}, RESP_OKAY);
      rd(OFS_FALL, {26'h0, n[5:0]}, RESP_OKAY);
      lo = (n != 0) ? 8 * n + 1 : 1;
      hi = (n != 0) ? 8 * n + 12 : 5;
      data_in <= 0;
      repeat (3) @(posedge core_clk);
      data_in <= 1;
      repeat (3) @(posedge core_clk);
      data_in <= 0;
      meas(1, 1, lo, hi);
      data_in <= 1;
      meas(0, 1, lo, hi);
    end
    $display("test delays done");
    rst_b <= 0;
    repeat (2) @(posedge core_clk);
    rst_b <= 1;
    rd(OFS_FALL, 0, RESP_OKAY);
    $display("test reset done");
    wr(OFS_FALL, 2, RESP_OKAY);
    wr(OFS_CTRL, 0, RESP_OKAY);
    data_in <= 0;
    meas(1, 1, 17, 28);
    shutdown_in <= 1;
    meas(1, 0, 1, 30);
    wr(OFS_CTRL, 32'h0000_00FC, RESP_OKAY);
    repeat (2) @(posedge core_clk);
    cmp_drv(8'hFF);
    wr(OFS_CTRL, 32'h0000_0005, RESP_OKAY);
    repeat (2) @(posedge core_clk);
    cmp_drv(8'h00);
    rd(OFS_CTRL, 32'h0000_0005, RESP_OKAY);
    $display("test shutdown done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
